// ### core/fcsf_defines.svh
/*
 flash command controller constants: command codes, status bits, bus timing counts.
 assumes a 200 MHz clock and a word-wide asynchronous flash bus.
*/
`ifndef FCSF_DEFINES_SVH
`define FCSF_DEFINES_SVH
`define FCSF_CMD_READ_ARRAY 8'hFF
`define FCSF_CMD_READ_STATUS 8'h70
`define FCSF_CMD_CLEAR_STATUS 8'h50
`define FCSF_CMD_PROG_SETUP 8'h40
`define FCSF_CMD_ERASE_SETUP 8'h20
`define FCSF_CMD_SUSPEND 8'hB0
`define FCSF_CMD_CONFIRM 8'hD0
`define FCSF_CMD_READ_CONFIG 8'h90
`define FCSF_CMD_QUERY 8'h98
`define FCSF_CMD_LOCK_SETUP 8'h60
`define FCSF_CMD_PROT_SETUP 8'hC0
`define FCSF_CMD_LOCK 8'h01
`define FCSF_CMD_LOCK_DOWN 8'h2F
`define FCSF_SR_READY_BIT 7
`define FCSF_SR_SUSP_BIT 2
`define FCSF_QUERY_HI_BYTE 8'h00
`define FCSF_STROBE_NS 70
`define FCSF_CLK_NS 5
`define FCSF_STROBE_CYC ((`FCSF_STROBE_NS + `FCSF_CLK_NS - 1) / `FCSF_CLK_NS)
`define FCSF_GAP_NS 20
`define FCSF_GAP_CYC ((`FCSF_GAP_NS + `FCSF_CLK_NS - 1) / `FCSF_CLK_NS)
`endif

// ### core/fcsf_pkg.sv
/*
 types of the flash command controller.
 assumes fcsf_defines.svh supplies the numeric constants.
*/
package fcsf_pkg;
   // user operations
   typedef enum logic [3:0] {
      FCSF_OP_READ_ARRAY, FCSF_OP_READ_STATUS, FCSF_OP_CLEAR_STATUS, FCSF_OP_PROGRAM,
      FCSF_OP_ERASE, FCSF_OP_SUSPEND, FCSF_OP_RESUME, FCSF_OP_READ_CONFIG,
      FCSF_OP_QUERY, FCSF_OP_LOCK, FCSF_OP_LOCK_DOWN, FCSF_OP_UNLOCK,
      FCSF_OP_PROT_PROG, FCSF_OP_READ_WORD
   } fcsf_op_t;
   // user request
   typedef struct packed {
      fcsf_op_t op;
      logic [21:0] addr;
      logic [15:0] data;
   } fcsf_req_t;
   // one bus cycle for the pin engine
   typedef struct packed {
      logic wr;
      logic [21:0] addr;
      logic [15:0] data;
   } fcsf_cyc_t;
   // flash pins driven by the controller
   typedef struct packed {
      logic ce_n;
      logic oe_n;
      logic we_n;
      logic [21:0] addr;
      logic [15:0] dq_out;
      logic dq_oe;
   } fcsf_pins_t;
endpackage

// ### core/fcsf_bus_cycle.sv
/*
 pin engine: one asynchronous read or write cycle on the flash bus.
 each read opens a fresh ce_n/oe_n assertion, so status is refreshed per read.
 assumes dq_in is already synchronised by the caller.
*/
`timescale 1ns/1ps
`include "fcsf_defines.svh"
module fcsf_bus_cycle
   import fcsf_pkg::*;
#(
   parameter int STROBE_CYC = `FCSF_STROBE_CYC,
   parameter int GAP_CYC = `FCSF_GAP_CYC
)(
   // clock and reset
   input wire logic clock,
   input wire logic arst_n,
   // cycle request
   input wire logic cyc_valid,
   output logic cyc_ready,
   input wire fcsf_cyc_t cyc,
   // cycle result
   output logic done,
   output logic [15:0] rdata,
   // flash side
   output fcsf_pins_t pins,
   input wire logic [15:0] dq_in
);
   typedef enum logic [1:0] {FCSF_B_IDLE, FCSF_B_STROBE, FCSF_B_GAP} fcsf_bstate_t;
   fcsf_bstate_t st_r;
   logic [7:0] cnt_r;
   logic wr_r;

   // not ready in the done cycle, so a request still held for it cannot start twice
   assign cyc_ready = (st_r == FCSF_B_IDLE) && !done;

   // strobe and recovery sequencing
   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         st_r <= FCSF_B_IDLE;
         cnt_r <= 8'h00;
         wr_r <= 1'b0;
      end
      else
      begin
         unique case (st_r)
            FCSF_B_IDLE:
               if (cyc_valid && cyc_ready)
               begin
                  st_r <= FCSF_B_STROBE;
                  cnt_r <= 8'(STROBE_CYC - 1);
                  wr_r <= cyc.wr;
               end
            FCSF_B_STROBE:
               if (cnt_r == 8'h00)
               begin
                  st_r <= FCSF_B_GAP;
                  cnt_r <= 8'(GAP_CYC - 1);
               end
               else
                  cnt_r <= cnt_r - 8'h01;
            FCSF_B_GAP:
               if (cnt_r == 8'h00)
                  st_r <= FCSF_B_IDLE;
               else
                  cnt_r <= cnt_r - 8'h01;
         endcase
      end
   end

   // pin drive; strobes high between cycles
   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         pins <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: '0, dq_out: '0, dq_oe: 1'b0};
      end
      else if (cyc_valid && cyc_ready)
      begin
         pins.ce_n <= 1'b0;
         pins.oe_n <= cyc.wr;
         pins.we_n <= !cyc.wr;
         pins.addr <= cyc.addr;
         pins.dq_out <= cyc.data;
         pins.dq_oe <= cyc.wr;
      end
      else if (st_r == FCSF_B_STROBE && cnt_r == 8'h00)
      begin
         pins.ce_n <= 1'b1;
         pins.oe_n <= 1'b1;
         pins.we_n <= 1'b1;
         pins.dq_oe <= 1'b0;
      end
   end

   // capture read data at strobe end
   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         rdata <= 16'h0000;
         done <= 1'b0;
      end
      else
      begin
         done <= (st_r == FCSF_B_GAP && cnt_r == 8'h00);
         if (st_r == FCSF_B_STROBE && cnt_r == 8'h00 && !wr_r)
            rdata <= dq_in;
      end
   end
endmodule

// ### core/fcsf_host.sv
/*
 host controller for a word-wide boot-block flash: turns user operations into
 command byte sequences, polls the status word, tracks the device command state.
 assumes one flash on the bus; dq_in comes from the pin and is synchronised here.
*/
// Overview of operation
// - suspend a running program by writing B0 at any address
// - write 70 at any address to enter status-read mode
// - each status poll is a fresh strobe assertion so status refreshes
// - write FF at any address returns to array read, also when suspended
// - while suspended, reads of the interrupted block are refused
// - write D0 while program suspended resumes it, device becomes busy again
`timescale 1ns/1ps
`include "fcsf_defines.svh"
module fcsf_host
   import fcsf_pkg::*;
#(
   parameter int BLOCK_SHIFT = 15,
   parameter int STROBE_CYC = `FCSF_STROBE_CYC,
   parameter int GAP_CYC = `FCSF_GAP_CYC
)(
   // clock and reset
   input wire logic clock,
   input wire logic arst_n,
   // user request
   input wire logic req_valid,
   output logic req_ready,
   input wire fcsf_req_t req,
   // user answer
   output logic rsp_valid,
   output logic [15:0] rsp_data,
   output logic rsp_refused,
   output logic suspended,
   output logic prog_done_on_suspend,
   // flash pins
   output fcsf_pins_t pins,
   input wire logic [15:0] dq_in
);
   typedef enum logic [2:0] {
      FCSF_H_IDLE, FCSF_H_CMD1, FCSF_H_CMD2, FCSF_H_POLL_CMD, FCSF_H_POLL, FCSF_H_READ, FCSF_H_RSP
   } fcsf_hstate_t;
   // device mode as tracked by the host
   typedef enum logic [2:0] {
      FCSF_D_ARRAY, FCSF_D_STATUS, FCSF_D_CONFIG, FCSF_D_QUERY,
      FCSF_D_PSUSP, FCSF_D_ESUSP
   } fcsf_dmode_t;

   fcsf_hstate_t st_r;
   fcsf_dmode_t mode_r;
   fcsf_req_t req_r;
   logic [15:0] dq_s1_r, dq_s2_r;
   logic [21:0] susp_addr_r;
   logic cyc_valid, cyc_done;
   fcsf_cyc_t cyc;
   logic [15:0] cyc_rdata;
   logic [7:0] c1, c2;
   logic two, poll;

   // same block test, used for suspend read protection
   function automatic logic same_block(input logic [21:0] a, input logic [21:0] b);
      return (a >> BLOCK_SHIFT) == (b >> BLOCK_SHIFT);
   endfunction

   // pin input synchroniser
   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         dq_s1_r <= 16'h0000;
         dq_s2_r <= 16'h0000;
      end
      else
      begin
         dq_s1_r <= dq_in;
         dq_s2_r <= dq_s1_r;
      end
   end

   // command bytes per operation
   always_comb
   begin
      c1 = `FCSF_CMD_READ_ARRAY;
      c2 = `FCSF_CMD_READ_ARRAY;
      two = 1'b0;
      poll = 1'b0;
      unique case (req_r.op)
         FCSF_OP_READ_ARRAY: c1 = `FCSF_CMD_READ_ARRAY;
         FCSF_OP_READ_STATUS: c1 = `FCSF_CMD_READ_STATUS;
         FCSF_OP_CLEAR_STATUS: c1 = `FCSF_CMD_CLEAR_STATUS;
         FCSF_OP_PROGRAM:
         begin
            c1 = `FCSF_CMD_PROG_SETUP;
            c2 = req_r.data[7:0];
            // no poll, the program stays suspendable
            two = 1'b1;
         end
         FCSF_OP_ERASE:
         begin
            c1 = `FCSF_CMD_ERASE_SETUP;
            c2 = `FCSF_CMD_CONFIRM;
            two = 1'b1;
            poll = 1'b1;
         end
         FCSF_OP_SUSPEND:
         begin
            c1 = `FCSF_CMD_SUSPEND;
            poll = 1'b1;
         end
         FCSF_OP_RESUME: c1 = `FCSF_CMD_CONFIRM;
         FCSF_OP_READ_CONFIG: c1 = `FCSF_CMD_READ_CONFIG;
         FCSF_OP_QUERY: c1 = `FCSF_CMD_QUERY;
         FCSF_OP_LOCK:
         begin
            c1 = `FCSF_CMD_LOCK_SETUP;
            c2 = `FCSF_CMD_LOCK;
            two = 1'b1;
         end
         FCSF_OP_LOCK_DOWN:
         begin
            c1 = `FCSF_CMD_LOCK_SETUP;
            c2 = `FCSF_CMD_LOCK_DOWN;
            two = 1'b1;
         end
         FCSF_OP_UNLOCK:
         begin
            c1 = `FCSF_CMD_LOCK_SETUP;
            c2 = `FCSF_CMD_CONFIRM;
            two = 1'b1;
         end
         FCSF_OP_PROT_PROG:
         begin
            c1 = `FCSF_CMD_PROT_SETUP;
            c2 = req_r.data[7:0];
            two = 1'b1;
            poll = 1'b1;
         end
         FCSF_OP_READ_WORD: c1 = `FCSF_CMD_READ_ARRAY;
      endcase
   end

   // bus cycle request
   always_comb
   begin
      cyc_valid = 1'b0;
      cyc = '{wr: 1'b1, addr: req_r.addr, data: {8'h00, c1}};
      unique case (st_r)
         FCSF_H_CMD1: cyc_valid = 1'b1;
         FCSF_H_CMD2:
         begin
            cyc_valid = 1'b1;
            cyc.data = (req_r.op == FCSF_OP_PROGRAM) ? req_r.data : {8'h00, c2};
         end
         FCSF_H_POLL_CMD:
         begin
            cyc_valid = 1'b1;
            cyc.data = {8'h00, `FCSF_CMD_READ_STATUS};
         end
         // every poll is its own strobe
         FCSF_H_POLL, FCSF_H_READ:
         begin
            cyc_valid = 1'b1;
            cyc.wr = 1'b0;
         end
         default: cyc_valid = 1'b0;
      endcase
   end

   assign req_ready = (st_r == FCSF_H_IDLE);

   // operation sequencer
   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         st_r <= FCSF_H_IDLE;
         req_r <= '0;
         rsp_data <= 16'h0000;
         rsp_refused <= 1'b0;
      end
      else
      begin
         unique case (st_r)
            FCSF_H_IDLE:
               if (req_valid)
               begin
                  req_r <= req;
                  rsp_refused <= 1'b0;
                  // no reads of the interrupted block while suspended
                  if (req.op == FCSF_OP_READ_WORD && mode_r == FCSF_D_PSUSP
                      && same_block(req.addr, susp_addr_r))
                  begin
                     rsp_refused <= 1'b1;
                     st_r <= FCSF_H_RSP;
                  end
                  else if (req.op == FCSF_OP_READ_WORD && mode_r != FCSF_D_ARRAY
                           && mode_r != FCSF_D_PSUSP && mode_r != FCSF_D_ESUSP)
                     st_r <= FCSF_H_CMD1;
                  else if (req.op == FCSF_OP_READ_WORD)
                     st_r <= FCSF_H_READ;
                  else
                     st_r <= FCSF_H_CMD1;
               end
            FCSF_H_CMD1:
               if (cyc_done)
                  st_r <= two ? FCSF_H_CMD2 : poll ? FCSF_H_POLL_CMD :
                          (req_r.op inside {FCSF_OP_READ_WORD, FCSF_OP_QUERY,
                           FCSF_OP_READ_CONFIG, FCSF_OP_READ_STATUS}) ? FCSF_H_READ : FCSF_H_RSP;
            FCSF_H_CMD2:
               if (cyc_done)
                  st_r <= poll ? FCSF_H_POLL_CMD : FCSF_H_RSP;
            FCSF_H_POLL_CMD:
               if (cyc_done)
                  st_r <= FCSF_H_POLL;
            FCSF_H_POLL:
               if (cyc_done && cyc_rdata[`FCSF_SR_READY_BIT])
               begin
                  rsp_data <= cyc_rdata;
                  st_r <= FCSF_H_RSP;
               end
            FCSF_H_READ:
               if (cyc_done)
               begin
                  // query words keep only the low byte
                  rsp_data <= (req_r.op == FCSF_OP_QUERY) ?
                              {`FCSF_QUERY_HI_BYTE, cyc_rdata[7:0]} : cyc_rdata;
                  st_r <= FCSF_H_RSP;
               end
            FCSF_H_RSP: st_r <= FCSF_H_IDLE;
         endcase
      end
   end

   assign rsp_valid = (st_r == FCSF_H_RSP);
   assign suspended = (mode_r == FCSF_D_PSUSP) || (mode_r == FCSF_D_ESUSP);

   // device mode tracking at the end of each operation
   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         mode_r <= FCSF_D_ARRAY;
         susp_addr_r <= '0;
         prog_done_on_suspend <= 1'b0;
      end
      else if (st_r == FCSF_H_RSP && !rsp_refused)
      begin
         unique case (req_r.op)
            FCSF_OP_READ_ARRAY, FCSF_OP_READ_WORD:
               mode_r <= (mode_r == FCSF_D_PSUSP || mode_r == FCSF_D_ESUSP) ?
                         mode_r : FCSF_D_ARRAY;
            FCSF_OP_QUERY: mode_r <= suspended ? mode_r : FCSF_D_QUERY;
            FCSF_OP_READ_CONFIG: mode_r <= suspended ? mode_r : FCSF_D_CONFIG;
            // bit 2 decides suspended or completed
            FCSF_OP_SUSPEND:
            begin
               prog_done_on_suspend <= !rsp_data[`FCSF_SR_SUSP_BIT];
               if (rsp_data[`FCSF_SR_SUSP_BIT])
                  mode_r <= FCSF_D_PSUSP;
               else
                  mode_r <= FCSF_D_STATUS;
            end
            // resume returns to busy, status mode
            FCSF_OP_RESUME: mode_r <= FCSF_D_STATUS;
            default: mode_r <= suspended ? mode_r : FCSF_D_STATUS;
         endcase
      end
      else if (st_r == FCSF_H_IDLE && req_valid && req.op == FCSF_OP_PROGRAM)
         susp_addr_r <= req.addr;
   end

   // pin engine
   fcsf_bus_cycle #(
      .STROBE_CYC(STROBE_CYC),
      .GAP_CYC(GAP_CYC)
   ) u_cycle (
      .clock(clock),
      .arst_n(arst_n),
      .cyc_valid(cyc_valid),
      .cyc_ready(),
      .cyc(cyc),
      .done(cyc_done),
      .rdata(cyc_rdata),
      .pins(pins),
      .dq_in(dq_s2_r)
   );
endmodule

// ### test/fcsf_host_asserts.sv
/*
 port checker of the flash host controller.
 assumes it is bound into fcsf_host and sees only its ports.
*/
`timescale 1ns/1ps
module fcsf_host_asserts
   import fcsf_pkg::*;
(
   // clock and reset
   input wire logic clock,
   input wire logic arst_n,
   // user side
   input wire logic req_valid,
   input wire logic req_ready,
   input wire fcsf_req_t req,
   input wire logic rsp_valid,
   input wire logic rsp_refused,
   input wire logic suspended,
   // flash pins
   input wire fcsf_pins_t pins
);
   fcsf_op_t op_r;
   logic b0_r, d0_r, ff_r, st_r;
   wire wr = !pins.ce_n && !pins.we_n;
   default clocking @(posedge clock); endclocking
   default disable iff (!arst_n);
   // op taken and the command bytes written since
   always_ff @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         op_r <= FCSF_OP_READ_ARRAY;
         {b0_r, d0_r, ff_r, st_r} <= 4'h0;
      end
      else if (req_valid && req_ready)
      begin
         op_r <= req.op;
         {b0_r, d0_r, ff_r, st_r} <= 4'h0;
      end
      else if (wr)
      begin
         b0_r <= b0_r | (pins.dq_out[7:0] == 8'hB0);
         d0_r <= d0_r | (pins.dq_out[7:0] == 8'hD0);
         ff_r <= ff_r | (pins.dq_out[7:0] == 8'hFF);
         st_r <= st_r | (pins.dq_out[7:0] == 8'h70);
      end
   end
   // a strobe holds ce_n low and its address stable for 7 cycles after it opens
   sequence s_strobe_held;
      ##1 (!pins.ce_n && $stable(pins.addr))[*7];
   endsequence
   // every read strobe closes again, so status refreshes
   sequence s_oe_ends;
      ##[1:40] $rose(pins.oe_n);
   endsequence
   chk_suspend_code: assert property (rsp_valid && op_r == FCSF_OP_SUSPEND |-> b0_r)
      else $error("suspend answered without a B0 write");
   chk_status_code: assert property (rsp_valid && op_r == FCSF_OP_READ_STATUS |-> st_r)
      else $error("status answered without a 70 write");
   chk_oe_toggle: assert property ($fell(pins.oe_n) |-> s_oe_ends)
      else $error("read strobe held too long");
   chk_strobe_hold: assert property ($fell(pins.ce_n) |-> s_strobe_held)
      else $error("strobe or address moved inside a cycle");
   chk_array_code: assert property (rsp_valid && op_r == FCSF_OP_READ_ARRAY |-> ff_r)
      else $error("array mode answered without an FF write");
   chk_refuse_susp: assert property (rsp_valid && rsp_refused |-> suspended && $past(pins.ce_n))
      else $error("refusal outside suspend or with a bus cycle");
   chk_resume_code: assert property (rsp_valid && op_r == FCSF_OP_RESUME |-> d0_r)
      else $error("resume answered without a D0 write");
   chk_write_drive: assert property (!pins.we_n |-> pins.dq_oe && pins.oe_n)
      else $error("write strobe without data drive");
endmodule
bind fcsf_host fcsf_host_asserts u_chk (.clock, .arst_n, .req_valid, .req_ready, .req,
   .rsp_valid, .rsp_refused, .suspended, .pins);

// ### test/fcsf_flash_model.sv
/*
 behavioural model of the word-wide flash on the host pins.
 assumes the host strobes are registered; they are sampled on the host clock.
*/
`timescale 1ns/1ps
module fcsf_flash_model
   import fcsf_pkg::*;
(
   // strobe sampling clock
   input wire logic clock,
   // flash pins
   input wire fcsf_pins_t pins,
   output logic [15:0] dq_in,
   // bench control and view
   input wire logic [15:0] busy_cyc,
   output logic prog_susp,
   output logic [7:0] lock_code
);
   localparam logic [2:0] M_ARR = 3'h0, M_STS = 3'h1, M_CFG = 3'h2, M_QRY = 3'h3;
   localparam logic [2:0] M_LCK = 3'h4, M_PRG = 3'h5, M_ERS = 3'h6;
   logic [2:0] mode = 3'h0;
   logic [15:0] wd = 16'h0000;
   logic [15:0] sr = 16'h0080;
   logic [15:0] last = 16'h0000;
   logic [15:0] rd_val;
   logic wr_prev = 1'b0;
   logic rd_prev = 1'b0;
   logic susp = 1'b0;
   logic prog_run = 1'b0;
   int busy = 0;
   wire rd = !pins.ce_n && !pins.oe_n;
   wire wr = !pins.ce_n && !pins.we_n;
   initial prog_susp = 1'b0;
   initial lock_code = 8'h00;
   always_comb
   begin
      case (mode)
         M_ARR: rd_val = pins.addr[15:0] ^ 16'h5A5A;
         M_CFG: rd_val = pins.addr[15:0] ^ 16'h0F0F;
         M_QRY: rd_val = {8'h00, pins.addr[7:0] ^ 8'hC3};
         default: rd_val = sr;
      endcase
   end
   // a released bus shows the inverse of the last word
   assign dq_in = rd ? rd_val : ~last;
   // strobe edges, sequencer count and command decode
   always @(posedge clock)
   begin
      rd_prev <= rd;
      wr_prev <= wr;
      if (rd)
         last <= dq_in;
      if (wr)
         wd <= pins.dq_out;
      if (busy > 0 && !susp)
         busy <= busy - 1;
      // status refreshed as a read opens
      if (rd && !rd_prev)
         sr <= {8'h00, (busy == 0 || susp), 4'h0, prog_susp, 2'h0};
      if (wr_prev && !wr)
      begin
         if (mode == M_PRG)
         begin
            busy <= int'(busy_cyc);
            prog_run <= 1'b1;
            mode <= M_STS;
         end
         else if (mode == M_ERS)
         begin
            busy <= (wd[7:0] == 8'hD0) ? int'(busy_cyc) : 0;
            prog_run <= 1'b0;
            mode <= M_STS;
         end
         else if (mode == M_LCK)
         begin
            lock_code <= wd[7:0];
            mode <= M_STS;
         end
         else if (busy > 0 && !susp)
         begin
            susp <= (wd[7:0] == 8'hB0);
            prog_susp <= prog_run && (wd[7:0] == 8'hB0);
            mode <= M_STS;
         end
         else
            case (wd[7:0])
               8'h70: mode <= M_STS;
               8'h90: mode <= M_CFG;
               8'h98: mode <= M_QRY;
               8'h60: mode <= M_LCK;
               8'h40, 8'h10, 8'hC0: mode <= M_PRG;
               8'h20: mode <= M_ERS;
               8'hD0:
               begin
                  susp <= 1'b0;
                  prog_susp <= 1'b0;
                  mode <= susp ? M_STS : M_ARR;
               end
               default: mode <= M_ARR;
            endcase
      end
   end
endmodule

// ### test/flash_cmd_suspend_fsm_test.sv
/*
 self-checking bench of the flash host controller.
 assumes the flash model on the pins and the bound port checker.
*/
`timescale 1ns/1ps
module flash_cmd_suspend_fsm_test
   import fcsf_pkg::*;
();
   logic clock = 1'b0;
   logic arst_n = 1'b0;
   logic req_valid = 1'b0;
   fcsf_req_t req = '0;
   logic req_ready, rsp_valid, rsp_refused, suspended, prog_done_on_suspend, m_susp, r_ref;
   logic [15:0] rsp_data, dq_in, r_data;
   logic [15:0] busy_cyc = 16'h0005;
   logic [7:0] m_lock;
   fcsf_pins_t pins;
   int n_fail = 0;
   int cmp_count = 0;
   int cyc = 0;
   // 200 MHz clock
   always #2.5 clock = ~clock;
   fcsf_host u_dut (.clock, .arst_n, .req_valid, .req_ready, .req, .rsp_valid, .rsp_data,
      .rsp_refused, .suspended, .prog_done_on_suspend, .pins, .dq_in);
   fcsf_flash_model u_flash (.clock, .pins, .dq_in, .busy_cyc, .prog_susp(m_susp),
      .lock_code(m_lock));
   // compare and count
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // one request, held until taken, then wait for the answer
   task automatic do_req(input fcsf_op_t op, input logic [21:0] a, input logic [15:0] d);
      req = '{op, a, d};
      req_valid = 1'b1;
      do @(posedge clock); while (req_ready !== 1'b1);
      #1 req_valid = 1'b0;
      do @(posedge clock); while (rsp_valid !== 1'b1);
      r_data = rsp_data;
      r_ref = rsp_refused;
      #1;
   endtask
   task automatic t_status();
      do_req(FCSF_OP_READ_STATUS, 22'h000123, 16'h0000);
      check(r_data, 16'h0080);
   endtask
   task automatic t_modes();
      do_req(FCSF_OP_QUERY, 22'h000010, 16'h0000);
      check(r_data, {8'h00, 8'h10 ^ 8'hC3});
      do_req(FCSF_OP_READ_CONFIG, 22'h000001, 16'h0000);
      check(r_data, 16'h0001 ^ 16'h0F0F);
      do_req(FCSF_OP_READ_ARRAY, 22'h000000, 16'h0000);
      do_req(FCSF_OP_READ_WORD, 22'h001234, 16'h0000);
      check(r_data, 16'h1234 ^ 16'h5A5A);
   endtask
   task automatic t_lock();
      fcsf_op_t ops[3] = '{FCSF_OP_LOCK, FCSF_OP_LOCK_DOWN, FCSF_OP_UNLOCK};
      logic [7:0] codes[3] = '{8'h01, 8'h2F, 8'hD0};
      for (int i = 0; i < 3; i++)
      begin
         do_req(ops[i], 22'h008000, 16'h0000);
         check({8'h00, m_lock}, {8'h00, codes[i]});
      end
   endtask
   // erase and protection program poll through busy reads until ready
   task automatic t_erase();
      busy_cyc = 16'h0020;
      do_req(FCSF_OP_ERASE, 22'h010000, 16'h0000);
      check(r_data, 16'h0080);
      do_req(FCSF_OP_PROT_PROG, 22'h000080, 16'h00AA);
      check(r_data, 16'h0080);
      do_req(FCSF_OP_CLEAR_STATUS, 22'h000000, 16'h0000);
      do_req(FCSF_OP_READ_WORD, 22'h000040, 16'h0000);
      check(r_data, 16'h0040 ^ 16'h5A5A);
   endtask
   // short program: suspend finds it complete
   task automatic t_susp_done();
      busy_cyc = 16'h0005;
      do_req(FCSF_OP_PROGRAM, 22'h008004, 16'hBEEF);
      do_req(FCSF_OP_SUSPEND, 22'h000000, 16'h0000);
      check({14'h0, suspended, prog_done_on_suspend}, 16'h0001);
   endtask
   // long program: suspend, guarded reads, resume
   task automatic t_susp_live();
      busy_cyc = 16'h0BB8;
      do_req(FCSF_OP_PROGRAM, 22'h008004, 16'h1234);
      do_req(FCSF_OP_SUSPEND, 22'h000000, 16'h0000);
      check({14'h0, suspended, prog_done_on_suspend}, 16'h0002);
      do_req(FCSF_OP_READ_STATUS, 22'h000000, 16'h0000);
      check(r_data, 16'h0084);
      do_req(FCSF_OP_READ_ARRAY, 22'h000000, 16'h0000);
      do_req(FCSF_OP_READ_WORD, 22'h00A000, 16'h0000);
      check({15'h0, r_ref}, 16'h0001);
      do_req(FCSF_OP_READ_WORD, 22'h000020, 16'h0000);
      check(r_data, 16'h0020 ^ 16'h5A5A);
      do_req(FCSF_OP_RESUME, 22'h000000, 16'h0000);
      check({15'h0, suspended | m_susp}, 16'h0000);
      do_req(FCSF_OP_READ_STATUS, 22'h000000, 16'h0000);
      check(r_data, 16'h0000);
   endtask
   // reset, then the scenarios
   initial
   begin
      repeat (10) @(posedge clock);
      #1 arst_n = 1'b1;
      t_status();
      t_modes();
      t_lock();
      t_erase();
      t_susp_done();
      t_susp_live();
      end_of_test();
   end
   // hang guard
   always @(posedge clock)
   begin
      cyc++;
      if (cyc == 40000)
      begin
         n_fail++;
         end_of_test();
      end
   end
endmodule
